// [verilog/fps_sizing_regs.sv]
`timescale 1ns/1ps
module fps_sizing_regs (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // register access
  input  wire logic        reg_sel,
  input  wire logic        reg_we,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // mode settings
  input  wire logic [15:0] aoi_width,
  input  wire logic [15:0] aoi_height,
  input  wire logic [7:0]  coding_id,
  input  wire logic [31:0] smart_extra_bytes,
  // to the packetiser
  output logic      [15:0] packet_bytes,
  output logic      [31:0] frame_packets,
  output logic             sizing_busy
);

  typedef struct packed {
    logic [31:0]         rdata;
    logic                ack;
    logic [31:0]         pixels;
    logic [47:0]         bytes;
    logic [31:0]         ppf;
    logic [15:0]         pkt;
    logic [15:0]         rec;
    logic [15:0]         width;
    logic [15:0]         height;
    logic [7:0]          coding;
    logic [31:0]         extra;
    logic                start;
    logic                pending;
    logic                busy;
    fps_pkg::fps_seq_type seq;
  } fps_regs_type;

  fps_regs_type s;
  fps_regs_type next_s;

  logic [31:0] calc_pixels;
  logic [47:0] calc_bytes;
  logic        ppf_done;
  logic [31:0] ppf_quot;
  logic [31:0] rec_quot;
  logic [16:0] rec_round;
  logic [15:0] rec_val;
  logic        changed;
  logic        wr_config;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  fps_frame_calc u_calc (
    .width       (aoi_width),
    .height      (aoi_height),
    .coding      (coding_id),
    .extra_bytes (smart_extra_bytes),
    .pixels      (calc_pixels),
    .bytes       (calc_bytes)
  );

  // ceiling division: packets per frame
  fps_divider u_ppf (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (s.start),
    .num   (s.bytes + {32'h0000_0000, s.pkt} - 48'h0000_0000_0001),
    .den   (s.pkt),
    .done  (ppf_done),
    .quot  (ppf_quot)
  );

  // fastest rate assumed to allow a fixed packet budget per frame
  fps_divider u_rec (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (s.start),
    .num   (s.bytes + {32'h0000_0000, fps_pkg::REC_PACKETS} - 48'h0000_0000_0001),
    .den   (fps_pkg::REC_PACKETS),
    .done  (),
    .quot  (rec_quot)
  );

  always_comb begin
    next_s    = s;
    wr_config = reg_sel && reg_we && hit(reg_addr, fps_pkg::OFS_PKT_CONFIG);
    changed   = (aoi_width != s.width) || (aoi_height != s.height) ||
                (coding_id != s.coding) || (smart_extra_bytes != s.extra) || wr_config;

    // recommended size on the step grid, within the limits
    rec_round = ({1'b0, rec_quot[15:0]} + 17'h0_0003) & ~17'h0_0003;
    if (rec_quot > {16'h0000, fps_pkg::PKT_MAX}) begin
      rec_val = fps_pkg::PKT_MAX;
    end else if (rec_round < {1'b0, fps_pkg::PKT_UNIT}) begin
      rec_val = fps_pkg::PKT_UNIT;
    end else begin
      rec_val = rec_round[15:0];
    end

    next_s.width  = aoi_width;
    next_s.height = aoi_height;
    next_s.coding = coding_id;
    next_s.extra  = smart_extra_bytes;
    next_s.pixels = calc_pixels;
    next_s.bytes  = calc_bytes;
    next_s.start  = 1'b0;
    next_s.ack    = reg_sel;
    next_s.rdata  = 32'h0000_0000;

    // only the low half is writable; all else ignores writes
    if (wr_config) begin
      next_s.pkt = reg_wdata[fps_pkg::FIELD_LO_LSB +: 16];
    end

    if (reg_sel && !reg_we) begin
      unique case (1'b1)
        hit(reg_addr, fps_pkg::OFS_COLOR_CAPS):  next_s.rdata = fps_pkg::COLOR_CAPS;
        hit(reg_addr, fps_pkg::OFS_PIXEL_COUNT): next_s.rdata = s.pixels;
        hit(reg_addr, fps_pkg::OFS_BYTES_HIGH):  next_s.rdata = {16'h0000, s.bytes[47:32]};
        hit(reg_addr, fps_pkg::OFS_BYTES_LOW):   next_s.rdata = s.bytes[31:0];
        hit(reg_addr, fps_pkg::OFS_PKT_LIMITS):  next_s.rdata = {fps_pkg::PKT_MAX,
                                                                 fps_pkg::PKT_UNIT};
        hit(reg_addr, fps_pkg::OFS_PKT_CONFIG):  next_s.rdata = {s.rec, s.pkt};
        hit(reg_addr, fps_pkg::OFS_PKT_COUNT):   next_s.rdata = s.ppf;
        default:                                 next_s.rdata = 32'h0000_0000;
      endcase
    end

    // a change during a run is remembered and rerun, never dropped
    unique case (s.seq)
      fps_pkg::SEQ_IDLE: begin
        if (changed || s.pending) begin
          next_s.start   = 1'b1;
          next_s.pending = 1'b0;
          next_s.seq     = fps_pkg::SEQ_WAIT;
        end
      end
      fps_pkg::SEQ_WAIT: begin
        if (changed) begin
          next_s.pending = 1'b1;
        end
        if (ppf_done) begin
          next_s.ppf = ppf_quot;
          next_s.rec = rec_val;
          next_s.seq = fps_pkg::SEQ_IDLE;
        end
      end
    endcase
    next_s.busy = (next_s.seq == fps_pkg::SEQ_WAIT);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s       <= '0;
      s.pkt   <= fps_pkg::PKT_SIZE_RESET;
      s.rec   <= fps_pkg::PKT_MAX;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata     = s.rdata;
  assign reg_ack       = s.ack;
  assign packet_bytes  = s.pkt;
  assign frame_packets = s.ppf;
  assign sizing_busy   = s.busy;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  logic [63:0] prod_hi;
  logic [63:0] prod_lo;
  assign prod_hi = {32'h0000_0000, s.ppf} * {48'h0000_0000_0000, s.pkt};
  assign prod_lo = {32'h0000_0000, s.ppf - 32'h0000_0001} * {48'h0000_0000_0000, s.pkt};

  AST_PIXELS: assert property (
    $past(rstn) |->
      s.pixels == ({16'h0000, $past(aoi_width)} * {16'h0000, $past(aoi_height)}))
    else $error("pixel count does not follow area size");

  AST_BYTES_SPLIT: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_BYTES_LOW)) |=>
      reg_ack && reg_rdata == $past(s.bytes[31:0]))
    else $error("low byte total read wrong");

  AST_QUADLET: assert property (
    (smart_extra_bytes[1:0] == 2'h0) |=> (s.bytes[1:0] == 2'h0))
    else $error("byte total not padded to a quadlet");

  AST_LIMITS: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_PKT_LIMITS)) |=>
      reg_ack && reg_rdata == 32'h1000_0004)
    else $error("packet limits read wrong");

  AST_PKT_WRITE: assert property (
    wr_config |=> packet_bytes == $past(reg_wdata[15:0]))
    else $error("packet size write not taken");

  AST_PPF_CEIL: assert property (
    (s.seq == fps_pkg::SEQ_WAIT && ppf_done && !changed && !s.pending &&
     s.pkt != 16'h0000 && s.bytes != 48'h0) |=>
      prod_hi >= {16'h0000, s.bytes} && prod_lo < {16'h0000, s.bytes})
    else $error("packets per frame not the rounded-up quotient");

  AST_REC_RANGE: assert property (
    s.rec[1:0] == 2'h0 && s.rec >= fps_pkg::PKT_UNIT && s.rec <= fps_pkg::PKT_MAX)
    else $error("recommended size off the grid");

  // a change mid-run reruns afterwards, so only a start from idle has a fixed length
  AST_RECOMPUTE: assert property (
    (changed && s.seq == fps_pkg::SEQ_IDLE) |-> ##[1:56] (s.seq == fps_pkg::SEQ_IDLE))
    else $error("recompute did not finish in time");

  AST_CAPS: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_COLOR_CAPS)) |=>
      reg_rdata == 32'h0000_0021)
    else $error("capability read wrong");

  AST_RO_WRITE: assert property (
    (reg_sel && reg_we && !wr_config && s.seq == fps_pkg::SEQ_IDLE && !changed) |=>
      $stable(s.rec) && $stable(s.ppf) && $stable(packet_bytes))
    else $error("write to read-only register changed state");

  AST_PIXEL_READ: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_PIXEL_COUNT)) |=>
      reg_ack && reg_rdata == $past(s.pixels))
    else $error("pixel count read wrong");

  AST_BYTES_HIGH: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_BYTES_HIGH)) |=>
      reg_ack && reg_rdata == {16'h0000, $past(s.bytes[47:32])})
    else $error("high byte total read wrong");

  AST_EXTRA_LSB: assert property (
    $past(rstn) |-> s.bytes[1:0] == $past(smart_extra_bytes[1:0]))
    else $error("smart feature bytes not added to the padded total");

  AST_CONFIG_READ: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_PKT_CONFIG)) |=>
      reg_ack && reg_rdata == {$past(s.rec), $past(packet_bytes)})
    else $error("packet config read wrong");

  AST_PKT_HOLD: assert property (
    !wr_config |=> $stable(packet_bytes))
    else $error("packet size changed without a write");

  AST_REC_NO_WRITE: assert property (
    (wr_config && !ppf_done) |=> $stable(s.rec))
    else $error("write reached the recommended size field");

  AST_REC_HOLD: assert property (
    !(s.seq == fps_pkg::SEQ_WAIT && ppf_done) |=> $stable(s.rec))
    else $error("recommended size moved outside a finished run");

  AST_PPF_HOLD: assert property (
    !(s.seq == fps_pkg::SEQ_WAIT && ppf_done) |=> $stable(frame_packets))
    else $error("packet count moved outside a finished run");

  AST_PPF_READ: assert property (
    (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_PKT_COUNT)) |=>
      reg_ack && reg_rdata == $past(frame_packets))
    else $error("packet count read wrong");

  AST_BUSY_START: assert property (
    (changed && s.seq == fps_pkg::SEQ_IDLE) |=> sizing_busy)
    else $error("change did not start a recompute");

  AST_START_PULSE: assert property (
    s.start |=> !s.start && sizing_busy)
    else $error("recompute start not a single pulse");

  AST_TOTALS_RO: assert property (
    (reg_sel && reg_we && !changed) |=> $stable(s.pixels) && $stable(s.bytes))
    else $error("write disturbed the frame totals");

  AST_ACK: assert property (
    reg_sel |=> reg_ack)
    else $error("access not answered");

  AST_ACK_NONE: assert property (
    !reg_sel |=> !reg_ack && reg_rdata == 32'h0000_0000)
    else $error("answer without an access");

  COV_PKT_WRITE: cover property (wr_config ##1 s.busy);
  COV_DONE:      cover property (s.busy ##1 !s.busy);
  COV_PENDING:   cover property (s.pending ##[1:60] !s.busy);
  COV_PPF_READ:  cover property (reg_sel && !reg_we && hit(reg_addr, fps_pkg::OFS_PKT_COUNT));

endmodule

// [verilog/fps_pkg.sv]
package fps_pkg;

  // register offsets
  localparam logic [11:0] OFS_COLOR_CAPS  = 12'h014;
  localparam logic [11:0] OFS_PIXEL_COUNT = 12'h034;
  localparam logic [11:0] OFS_BYTES_HIGH  = 12'h038;
  localparam logic [11:0] OFS_BYTES_LOW   = 12'h03c;
  localparam logic [11:0] OFS_PKT_LIMITS  = 12'h040;
  localparam logic [11:0] OFS_PKT_CONFIG  = 12'h044;
  localparam logic [11:0] OFS_PKT_COUNT   = 12'h048;

  // field positions
  localparam int FIELD_LO_LSB = 0;
  localparam int FIELD_HI_LSB = 16;

  // packet size figures
  localparam logic [15:0] PKT_UNIT       = 16'h0004;
  localparam logic [15:0] PKT_MAX        = 16'h1000;
  localparam logic [15:0] PKT_SIZE_RESET = 16'h1000;
  localparam logic [15:0] REC_PACKETS    = 16'h0400;

  // supported codings: mono 8 and mono 16
  localparam logic [31:0] COLOR_CAPS = 32'h0000_0021;

  // divider length in cycles
  localparam logic [5:0] DIV_STEPS = 6'h30;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_WAIT} fps_seq_type;

  // bytes per pixel times two, 0 for codings that are not supported
  function automatic logic [3:0] fps_bytes_x2(input logic [7:0] id);
    logic [3:0] r;
    r = 4'h0;
    if (COLOR_CAPS[id[4:0]] && id < 8'h0b) begin
      unique case (id)
        8'h00, 8'h09:         r = 4'h2;
        8'h01:                r = 4'h3;
        8'h02, 8'h05, 8'h07,
        8'h0a:                r = 4'h4;
        8'h03, 8'h04:         r = 4'h6;
        default:              r = 4'hc;
      endcase
    end
    return r;
  endfunction

endpackage

// [verilog/fps_frame_calc.sv]
`timescale 1ns/1ps
module fps_frame_calc (
  // settings
  input  wire logic [15:0] width,
  input  wire logic [15:0] height,
  input  wire logic [7:0]  coding,
  input  wire logic [31:0] extra_bytes,
  // totals
  output logic      [31:0] pixels,
  output logic      [47:0] bytes
);

  logic [35:0] half_bytes;
  logic [35:0] image_bytes;
  logic [35:0] padded;

  always_comb begin
    pixels      = {16'h0000, width} * {16'h0000, height};
    half_bytes  = {4'h0, pixels} * {32'h0000_0000, fps_pkg::fps_bytes_x2(coding)};
    // odd half-byte rounds up to a whole byte
    image_bytes = (half_bytes + 36'h0_0000_0001) >> 1;
    // quadlet padding, then bytes added by smart features
    padded      = (image_bytes + 36'h0_0000_0003) & ~36'h0_0000_0003;
    bytes       = {12'h000, padded} + {16'h0000, extra_bytes};
  end

endmodule

// [verilog/fps_divider.sv]
`timescale 1ns/1ps
module fps_divider (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // request
  input  wire logic        start,
  input  wire logic [47:0] num,
  input  wire logic [15:0] den,
  // answer
  output logic             done,
  output logic      [31:0] quot
);

  typedef struct packed {
    logic [5:0]  cnt;
    logic [16:0] rem;
    logic [47:0] q;
    logic [15:0] den;
    logic        busy;
    logic        done;
    logic [31:0] quot;
  } fps_div_type;

  fps_div_type s;
  fps_div_type next_s;
  logic [16:0] shifted;

  always_comb begin
    next_s  = s;
    shifted = {s.rem[15:0], s.q[47]};
    next_s.done = 1'b0;
    if (start) begin
      next_s.q    = num;
      next_s.rem  = 17'h0_0000;
      next_s.den  = den;
      next_s.cnt  = fps_pkg::DIV_STEPS;
      next_s.busy = 1'b1;
    end else if (s.busy) begin
      if (shifted >= {1'b0, s.den}) begin
        next_s.rem = shifted - {1'b0, s.den};
        next_s.q   = {s.q[46:0], 1'b1};
      end else begin
        next_s.rem = shifted;
        next_s.q   = {s.q[46:0], 1'b0};
      end
      next_s.cnt = s.cnt - 6'h01;
      if (s.cnt == 6'h01) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        // zero divisor or oversize result saturates
        if (s.den == 16'h0000 || next_s.q[47:32] != 16'h0000) begin
          next_s.quot = 32'hffff_ffff;
        end else begin
          next_s.quot = next_s.q[31:0];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quot = s.quot;

endmodule

// [tb/fps_host.sv]
`timescale 1ns/1ps
module fps_host (
  // clock
  input  wire logic        mclk,
  // register access
  output logic             reg_sel,
  output logic             reg_we,
  output logic      [11:0] reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_ack,
  // mode settings
  output logic      [15:0] aoi_width,
  output logic      [15:0] aoi_height,
  output logic      [7:0]  coding_id,
  output logic      [31:0] smart_extra_bytes
);
  initial begin
    reg_sel = 1'b0;
    reg_we = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    {aoi_width, aoi_height, coding_id, smart_extra_bytes} = '0;
  end

  // one-cycle strobe; released bus shows inverted data, never the last value
  task automatic host_write(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    {reg_sel, reg_we, reg_addr, reg_wdata} = {2'b11, a, d};
    @(negedge mclk);
    {reg_sel, reg_we, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask

  // answer stands one cycle, so it is taken at the falling edge after the taking edge
  task automatic host_read(input logic [11:0] a, output logic [31:0] d, output logic ok);
    @(negedge mclk);
    {reg_sel, reg_we, reg_addr} = {2'b10, a};
    @(negedge mclk);
    {reg_sel, reg_addr} = {1'b0, ~a};
    d = reg_rdata;
    ok = reg_ack;
  endtask

  // settings come from the neighbouring image size and coding registers
  task automatic host_set(input logic [15:0] w, input logic [15:0] h,
                          input logic [7:0] c, input logic [31:0] x);
    @(negedge mclk);
    {aoi_width, aoi_height, coding_id, smart_extra_bytes} = {w, h, c, x};
  endtask
endmodule

// [tb/test_fps_sizing_regs.sv]
`timescale 1ns/1ps
module test_fps_sizing_regs;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_sel, reg_we, reg_ack, sizing_busy;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, smart_extra_bytes, frame_packets;
  logic [15:0] aoi_width, aoi_height, packet_bytes;
  logic [7:0]  coding_id;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #20 mclk = ~mclk;

  fps_host host (.mclk(mclk), .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .aoi_width(aoi_width), .aoi_height(aoi_height), .coding_id(coding_id),
    .smart_extra_bytes(smart_extra_bytes));

  fps_sizing_regs dut (.mclk(mclk), .rstn(rstn), .reg_sel(reg_sel), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .aoi_width(aoi_width), .aoi_height(aoi_height), .coding_id(coding_id),
    .smart_extra_bytes(smart_extra_bytes), .packet_bytes(packet_bytes),
    .frame_packets(frame_packets), .sizing_busy(sizing_busy));

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host.host_read(a, d, ok);
    chk("reg_ack", 32'h0000_0001, {31'h0, ok});
    chk($sformatf("register %h", a), exp, d);
  endtask

  // bounded wait; returns at the first idle cycle, even the one between a run and its rerun
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(negedge mclk);
    while (sizing_busy !== 1'b0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) chk("sizing_busy", 32'h0, 32'h1);
  endtask

  task automatic cfg(input logic [15:0] w, input logic [15:0] h, input logic [7:0] c,
                     input logic [31:0] x, input logic [15:0] p);
    longint pix, t, r, pk;
    host.host_set(w, h, c, x);
    wait_idle();
    host.host_write(fps_pkg::OFS_PKT_CONFIG, {16'hffff, p});
    wait_idle();
    pix = longint'(w) * longint'(h);
    t = (c == 8'h00) ? pix : (c == 8'h05) ? 2 * pix : 0;
    t = (t + 3) / 4 * 4 + longint'(x);
    r = (t + 1023) / 1024;
    r = (r + 3) / 4 * 4;
    r = (r < 4) ? 4 : (r > 4096) ? 4096 : r;
    pk = (t + longint'(p) - 1) / longint'(p);
    rd(fps_pkg::OFS_PIXEL_COUNT, pix[31:0]);
    rd(fps_pkg::OFS_BYTES_HIGH, {16'h0, t[47:32]});
    rd(fps_pkg::OFS_BYTES_LOW, t[31:0]);
    rd(fps_pkg::OFS_PKT_CONFIG, {r[15:0], p});
    rd(fps_pkg::OFS_PKT_COUNT, pk[31:0]);
    chk("packet_bytes", {16'h0, p}, {16'h0, packet_bytes});
    chk("frame_packets", pk[31:0], frame_packets);
  endtask

  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    rd(fps_pkg::OFS_PKT_CONFIG, 32'h1000_1000);
    rd(fps_pkg::OFS_PKT_LIMITS, 32'h1000_0004);
    rd(fps_pkg::OFS_COLOR_CAPS, 32'h0000_0021);
    rd(12'h100, 32'h0000_0000);
    // packet size stays large enough for at most 4095 packets, except the wide case:
    // a total above 4095 maximal packets has no legal size, yet the high quadlet needs it
    cfg(16'd640, 16'd480, 8'h00, 32'h0, 16'd4096);
    cfg(16'd640, 16'd480, 8'h00, 32'h0, 16'd300);
    cfg(16'd641, 16'd3, 8'h00, 32'h5, 16'd1000);
    cfg(16'd100, 16'd50, 8'h05, 32'h10, 16'd8);
    cfg(16'd64, 16'd64, 8'h02, 32'h0, 16'd64);
    cfg(16'hffff, 16'hffff, 8'h05, 32'h0, 16'd4096);
    host.host_write(fps_pkg::OFS_PIXEL_COUNT, 32'h0);
    host.host_write(fps_pkg::OFS_PKT_LIMITS, 32'h0);
    rd(fps_pkg::OFS_PIXEL_COUNT, 32'hfffe_0001);
    rd(fps_pkg::OFS_PKT_LIMITS, 32'h1000_0004);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
endmodule
